//--- hw/rgc_gpio_config.sv
`timescale 1ns/100ps
module rgc_gpio_config (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic second_port_select,
  input wire logic [1:0] link_up,
  input wire logic [5:0] remote_val,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  output logic [7:0] func_in,
  output logic [7:0] gpio_in,
  output logic link_status
);

  // ==========================================================================
  // Configuration storage, one entry per pin slot
  rgc_pkg::rgc_pin_cfg_t cfg_r [rgc_pkg::NUM_SLOTS];
  logic [7:0] reg_rdata_nxt;
  logic [2:0] base;
  logic first_r;

  // Second port select moves the remote pin bank
  assign base = second_port_select ? 3'(rgc_pkg::SLOT_PORT1) : 3'h0; // RULE_08

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < rgc_pkg::NUM_SLOTS; i++) begin
        cfg_r[i] <= rgc_pkg::CFG_RESET; // RULE_07
      end
    end else if (reg_wr_en) begin
      case (reg_addr)
        rgc_pkg::ADDR_PIN_ONE_TWO: begin
          cfg_r[base] <= reg_wdata[rgc_pkg::LO_FIELD_LSB +: rgc_pkg::FIELD_W]; // RULE_08
          cfg_r[base + 3'h1] <= reg_wdata[rgc_pkg::HI_FIELD_LSB +: rgc_pkg::FIELD_W];
        end
        rgc_pkg::ADDR_PIN_THREE: begin
          cfg_r[base + 3'h2] <= reg_wdata[rgc_pkg::LO_FIELD_LSB +: rgc_pkg::FIELD_W];
        end
        rgc_pkg::ADDR_PIN_FIVE_SIX: begin
          cfg_r[rgc_pkg::SLOT_PIN_FIVE] <= {reg_wdata[rgc_pkg::OUT_BIT], 1'b0,
            reg_wdata[rgc_pkg::LO_FIELD_LSB +: rgc_pkg::LOCAL_MODE_W]}; // RULE_10
          cfg_r[rgc_pkg::SLOT_PIN_SIX] <= {reg_wdata[rgc_pkg::HI_FIELD_LSB + rgc_pkg::OUT_BIT], 1'b0,
            reg_wdata[rgc_pkg::HI_FIELD_LSB +: rgc_pkg::LOCAL_MODE_W]}; // RULE_09
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Register read; reserved bits and unmapped addresses read zero
  always_comb begin
    reg_rdata_nxt = rgc_pkg::REG_RESET;
    case (reg_addr)
      rgc_pkg::ADDR_PIN_ONE_TWO: begin
        reg_rdata_nxt = {cfg_r[base + 3'h1], cfg_r[base]}; // RULE_08
      end
      rgc_pkg::ADDR_PIN_THREE: begin
        reg_rdata_nxt = {4'h0, cfg_r[base + 3'h2]};
      end
      rgc_pkg::ADDR_PIN_FIVE_SIX: begin
        reg_rdata_nxt = {cfg_r[rgc_pkg::SLOT_PIN_SIX].out_val, 1'b0,
          cfg_r[rgc_pkg::SLOT_PIN_SIX].mode[1:0],
          cfg_r[rgc_pkg::SLOT_PIN_FIVE].out_val, 1'b0,
          cfg_r[rgc_pkg::SLOT_PIN_FIVE].mode[1:0]};
      end
      default: begin
        reg_rdata_nxt = rgc_pkg::REG_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= rgc_pkg::REG_RESET;
    end else if (reg_rd_en) begin
      reg_rdata <= reg_rdata_nxt;
    end
  end

  // ==========================================================================
  // Port-selected link status
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      link_status <= 1'b0;
    end else begin
      link_status <= second_port_select ? link_up[1] : link_up[0]; // RULE_11
    end
  end

  // ==========================================================================
  // Pin cells
  for (genvar g = 0; g < rgc_pkg::NUM_SLOTS; g++) begin : g_pin
    localparam bit IS_REMOTE = (g < rgc_pkg::SLOT_PIN_FIVE) || (g >= rgc_pkg::SLOT_PORT1);
    localparam int PORT = (g >= rgc_pkg::SLOT_PORT1) ? 1 : 0;
    localparam int RIDX = (g >= rgc_pkg::SLOT_PORT1) ? g - 2 : (IS_REMOTE ? g : 0);
    logic rval;
    logic lnk;
    assign rval = IS_REMOTE ? remote_val[RIDX] : 1'b0;
    assign lnk = IS_REMOTE ? link_up[PORT] : 1'b0;
    rgc_pin_cell #(
      .REMOTE(IS_REMOTE)
    ) u_cell (
      .mclk(mclk),
      .rst_b(rst_b),
      .cfg(cfg_r[g]),
      .remote_val(rval),
      .link_up(lnk),
      .pin_i(pin_i[g]),
      .pin_o(pin_o[g]),
      .pin_oe(pin_oe[g]),
      .func_in(func_in[g]),
      .gpio_in(gpio_in[g])
    );
  end

  // ==========================================================================
  // Checks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  property p_reset_zero;
    @(posedge mclk) disable iff (!rst_b)
    first_r |-> (cfg_r[0] == 4'h0 && cfg_r[1] == 4'h0 && cfg_r[2] == 4'h0 && cfg_r[3] == 4'h0
      && cfg_r[4] == 4'h0 && cfg_r[5] == 4'h0 && cfg_r[6] == 4'h0 && cfg_r[7] == 4'h0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("configuration not zero after reset"); // RULE_07

  property p_port_steer;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr_en && second_port_select && reg_addr == rgc_pkg::ADDR_PIN_THREE)
      |=> (cfg_r[7] == $past(reg_wdata[3:0]) && $stable(cfg_r[2]));
  endproperty
  a_port_steer: assert property (p_port_steer) else $error("second port write misdirected"); // RULE_08

  property p_pin_six;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == rgc_pkg::ADDR_PIN_FIVE_SIX && reg_wdata[5:4] == 2'h1)
      ##1 !(reg_wr_en && reg_addr == rgc_pkg::ADDR_PIN_FIVE_SIX)
      |=> (pin_oe[4] && pin_o[4] == $past(reg_wdata[7], 2));
  endproperty
  a_pin_six: assert property (p_pin_six) else $error("pin six local output not driven"); // RULE_09

  property p_link_status;
    @(posedge mclk) disable iff (!rst_b)
    $stable(second_port_select) && second_port_select |=> link_status == $past(link_up[1]);
  endproperty
  a_link_status: assert property (p_link_status) else $error("status not from second port"); // RULE_11

  property p_link_status_first;
    @(posedge mclk) disable iff (!rst_b)
    $stable(second_port_select) && !second_port_select
      |=> link_status == $past(link_up[0]);
  endproperty
  a_link_status_first: assert property (p_link_status_first) else $error("status not from first port"); // RULE_11

  // ==========================================================================
  // Port steering checks
  property p_pair_steer;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr_en && second_port_select && reg_addr == rgc_pkg::ADDR_PIN_ONE_TWO)
      |=> (cfg_r[5] == $past(reg_wdata[3:0]) && cfg_r[6] == $past(reg_wdata[7:4])
      && $stable(cfg_r[0]) && $stable(cfg_r[1]));
  endproperty
  a_pair_steer: assert property (p_pair_steer) else $error("second port pair write misdirected"); // RULE_08

  property p_first_steer;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr_en && !second_port_select && reg_addr == rgc_pkg::ADDR_PIN_THREE)
      |=> (cfg_r[2] == $past(reg_wdata[3:0]) && $stable(cfg_r[7]));
  endproperty
  a_first_steer: assert property (p_first_steer) else $error("first port write misdirected"); // RULE_08

  property p_pair_read;
    @(posedge mclk) disable iff (!rst_b)
    (reg_rd_en && second_port_select && reg_addr == rgc_pkg::ADDR_PIN_ONE_TWO)
      |=> reg_rdata == {$past(cfg_r[6]), $past(cfg_r[5])};
  endproperty
  a_pair_read: assert property (p_pair_read) else $error("second port pair read misdirected"); // RULE_08

  property p_three_read_first;
    @(posedge mclk) disable iff (!rst_b)
    (reg_rd_en && !second_port_select && reg_addr == rgc_pkg::ADDR_PIN_THREE)
      |=> reg_rdata == {4'h0, $past(cfg_r[2])};
  endproperty
  a_three_read_first: assert property (p_three_read_first) else $error("first port read misdirected"); // RULE_08

  property p_three_read_second;
    @(posedge mclk) disable iff (!rst_b)
    (reg_rd_en && second_port_select && reg_addr == rgc_pkg::ADDR_PIN_THREE)
      |=> reg_rdata == {4'h0, $past(cfg_r[7])};
  endproperty
  a_three_read_second: assert property (p_three_read_second) else $error("second port read misdirected"); // RULE_08

  // ==========================================================================
  // Pins five and six checks
  property p_local_mode;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == rgc_pkg::ADDR_PIN_FIVE_SIX)
      |=> (!cfg_r[3].mode[2] && !cfg_r[4].mode[2] && $stable(cfg_r[0]) && $stable(cfg_r[5]));
  endproperty
  a_local_mode: assert property (p_local_mode) else $error("local pin write reached a remote mode"); // RULE_10

  property p_reserved_read;
    @(posedge mclk) disable iff (!rst_b)
    (reg_rd_en && reg_addr == rgc_pkg::ADDR_PIN_FIVE_SIX) |=> (!reg_rdata[6] && !reg_rdata[2]);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bit reads one"); // RULE_10

  property p_pin_five;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == rgc_pkg::ADDR_PIN_FIVE_SIX && reg_wdata[1:0] == 2'h1)
      ##1 !(reg_wr_en && reg_addr == rgc_pkg::ADDR_PIN_FIVE_SIX)
      |=> (pin_oe[3] && pin_o[3] == $past(reg_wdata[3], 2));
  endproperty
  a_pin_five: assert property (p_pin_five) else $error("pin five local output not driven"); // RULE_10

  property p_six_drive;
    @(posedge mclk) disable iff (!rst_b)
    pin_oe[4] |-> pin_o[4] == $past(cfg_r[4].out_val);
  endproperty
  a_six_drive: assert property (p_six_drive) else $error("pin six drives other than its local bit"); // RULE_09

endmodule

//--- hw/rgc_pin_cell.sv
`timescale 1ns/100ps
module rgc_pin_cell #(
  parameter bit REMOTE = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire rgc_pkg::rgc_pin_cfg_t cfg,
  input wire logic remote_val,
  input wire logic link_up,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic func_in,
  output logic gpio_in
);

  // ==========================================================================
  // Pin input synchroniser
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic pin_lvl_r;
  logic held_r;
  logic [2:0] mode;
  logic drv_nxt;
  logic oe_nxt;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_lvl_r <= 1'b0;
    end else if (sync2_r == sync3_r) begin
      pin_lvl_r <= sync3_r;
    end
  end

  // ==========================================================================
  // Last remote value, frozen while the link is down
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      held_r <= 1'b0;
    end else if (link_up) begin
      held_r <= remote_val; // RULE_05
    end
  end

  // ==========================================================================
  // Mode decode
  assign mode = REMOTE ? cfg.mode : {1'b0, cfg.mode[1:0]}; // RULE_10

  always_comb begin
    drv_nxt = 1'b0;
    oe_nxt = 1'b0;
    case (mode)
      rgc_pkg::MODE_LOCAL_OUT: begin
        drv_nxt = cfg.out_val; // RULE_01 RULE_03 RULE_09
        oe_nxt = 1'b1;
      end
      rgc_pkg::MODE_REMOTE_HOLD: begin
        drv_nxt = link_up ? remote_val : held_r; // RULE_05
        oe_nxt = 1'b1;
      end
      rgc_pkg::MODE_REMOTE_DFLT: begin
        drv_nxt = link_up ? remote_val : cfg.out_val; // RULE_06
        oe_nxt = 1'b1;
      end
      default: begin
        drv_nxt = 1'b0; // RULE_02 RULE_04
        oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o <= drv_nxt;
      pin_oe <= oe_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      func_in <= 1'b0;
      gpio_in <= 1'b0;
    end else begin
      func_in <= (mode[1:0] == rgc_pkg::MODE_LO_FUNC) ? pin_lvl_r : 1'b0; // RULE_02
      gpio_in <= (mode == rgc_pkg::MODE_LOCAL_IN) ? pin_lvl_r : 1'b0; // RULE_04
    end
  end

  // ==========================================================================
  // Checks
  property p_local_out;
    @(posedge mclk) disable iff (!rst_b)
    (mode == rgc_pkg::MODE_LOCAL_OUT) |=> (pin_oe && pin_o == $past(cfg.out_val));
  endproperty
  a_local_out: assert property (p_local_out) else $error("local output not driven"); // RULE_03

  property p_tristate;
    @(posedge mclk) disable iff (!rst_b)
    (mode[1:0] == rgc_pkg::MODE_LO_TRI) |=> !pin_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pin driven in high impedance mode"); // RULE_02

  property p_input;
    @(posedge mclk) disable iff (!rst_b)
    (mode == rgc_pkg::MODE_LOCAL_IN) [*2] |=> (!pin_oe && gpio_in == $past(pin_lvl_r));
  endproperty
  a_input: assert property (p_input) else $error("input mode drives pin or loses level"); // RULE_04

  property p_hold;
    @(posedge mclk) disable iff (!rst_b)
    (mode == rgc_pkg::MODE_REMOTE_HOLD && !link_up) ##1
    (mode == rgc_pkg::MODE_REMOTE_HOLD && !link_up) |=> (pin_o == $past(pin_o));
  endproperty
  a_hold: assert property (p_hold) else $error("hold mode changed value on link loss"); // RULE_05

  property p_remote;
    @(posedge mclk) disable iff (!rst_b)
    (mode[0] && mode[2] && link_up) |=> (pin_oe && pin_o == $past(remote_val));
  endproperty
  a_remote: assert property (p_remote) else $error("remote value not driven"); // RULE_05

  property p_default;
    @(posedge mclk) disable iff (!rst_b)
    (mode == rgc_pkg::MODE_REMOTE_DFLT && !link_up) |=> (pin_o == $past(cfg.out_val));
  endproperty
  a_default: assert property (p_default) else $error("default value not used on link loss"); // RULE_06

  property p_local_only;
    @(posedge mclk) disable iff (!rst_b)
    pin_oe && !$past(mode[2]) |-> pin_o == $past(cfg.out_val);
  endproperty
  a_local_only: assert property (p_local_only) else $error("local bit not on driven pin"); // RULE_01

endmodule

//--- inc/rgc_pkg.sv
// Behaviour
// [RULE_01] Local output bit drives a pin only when enabled, output, not remote; the code also drives it in mode 111 on link loss.
// [RULE_02] Mode x00 gives functional input; mode x10 gives high impedance.
// [RULE_03] Mode 001 drives the pin from the local output-value bit.
// [RULE_04] Mode 011 makes the pin a general-purpose input.
// [RULE_05] Mode 101 drives the remote value and keeps the last one on link loss.
// [RULE_06] Mode 111 drives the remote value, local output bit on link loss.
// [RULE_07] Output-value and mode fields read zero after reset.
// [RULE_08] Second-port select steers pin register accesses to the second port's pins.
// [RULE_09] Pin six drives its local bit when enabled and set as output.
// [RULE_10] Two-bit modes: 00 functional in, 10 high-Z, 01 output, 11 input.
// [RULE_11] Port-selected status reports the second port while select is set.
package rgc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_PIN_ONE_TWO = 8'h0E;
  localparam logic [7:0] ADDR_PIN_THREE = 8'h0F;
  localparam logic [7:0] ADDR_PIN_FIVE_SIX = 8'h10;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 4;
  localparam int FIELD_W = 4;
  localparam int OUT_BIT = 3;
  localparam int LOCAL_MODE_W = 2;

  // ==========================================================================
  // Pin modes
  localparam logic [2:0] MODE_LOCAL_OUT = 3'h1;
  localparam logic [2:0] MODE_LOCAL_IN = 3'h3;
  localparam logic [2:0] MODE_REMOTE_HOLD = 3'h5;
  localparam logic [2:0] MODE_REMOTE_DFLT = 3'h7;
  localparam logic [1:0] MODE_LO_FUNC = 2'h0;
  localparam logic [1:0] MODE_LO_TRI = 2'h2;

  // ==========================================================================
  // Pin slots: 0..2 first port remote pins, 3..4 local pins five and six,
  // 5..7 second port remote pins
  localparam int NUM_SLOTS = 8;
  localparam int SLOT_PIN_FIVE = 3;
  localparam int SLOT_PIN_SIX = 4;
  localparam int SLOT_PORT1 = 5;

  typedef struct packed {
    logic out_val;
    logic [2:0] mode;
  } rgc_pin_cfg_t;

  localparam rgc_pin_cfg_t CFG_RESET = 4'h0;

endpackage

//--- tb/rgc_deser_model.sv
`timescale 1ns/100ps
module rgc_deser_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [1:0] link_cmd,
  input wire logic [5:0] val_cmd,
  output logic [1:0] link_up,
  output logic [5:0] remote_val
);
  // ==========================================================================
  // Back channel: values are valid only while the port's link is up
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      link_up <= 2'h0;
      remote_val <= 6'h00;
    end else begin
      link_up <= link_cmd;
      for (int i = 0; i < 6; i++) begin
        // A dead link inverts the value every cycle instead of holding the last good value
        remote_val[i] <= link_cmd[i / 3] ? val_cmd[i] : ~remote_val[i];
      end
    end
  end
endmodule

//--- tb/tb_remote_capable_gpio_config.sv
`timescale 1ns/100ps
module tb_remote_capable_gpio_config;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic second_port_select = 1'b0;
  logic [1:0] link_cmd = 2'h3;
  logic [5:0] val_cmd = 6'h00;
  logic [1:0] link_up;
  logic [5:0] remote_val;
  logic [7:0] pin_i = 8'hFF;
  logic [7:0] pin_o;
  logic [7:0] pin_oe;
  logic [7:0] func_in;
  logic [7:0] gpio_in;
  logic link_status;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;

  // ==========================================================================
  // Instances
  rgc_gpio_config dut (.mclk(mclk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .second_port_select(second_port_select), .link_up(link_up), .remote_val(remote_val),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .func_in(func_in), .gpio_in(gpio_in),
    .link_status(link_status));
  rgc_deser_model deser (.mclk(mclk), .rst_b(rst_b), .link_cmd(link_cmd), .val_cmd(val_cmd),
    .link_up(link_up), .remote_val(remote_val));

  initial begin
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic results();
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk) #1;
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) #1;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge mclk) #1;
    reg_rd_en = 1'b0;
    @(posedge mclk) #1;
    cmp($sformatf("rdata@%h", a), exp, reg_rdata);
  endtask

  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask

  // Expected {oe, driven value, functional input, gpio input} for one pin
  function automatic logic [3:0] exp_pin(input logic [2:0] m, input logic ov, input logic rv, input logic lv);
    if (m[1:0] == 2'h0) return {3'h0, lv} << 1;
    if (m[1:0] == 2'h2) return 4'h0;
    if (m == 3'h1) return {1'b1, ov, 2'h0};
    if (m == 3'h3) return {3'h0, lv};
    return {1'b1, rv, 2'h0};
  endfunction

  task automatic chk_pin(input int s, input logic [3:0] exp);
    cmp($sformatf("pin%0d", s), {4'h0, exp}, {4'h0, pin_oe[s], pin_o[s] & pin_oe[s], func_in[s], gpio_in[s]});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    #1 rst_b = 1'b1;
    rd(rgc_pkg::ADDR_PIN_ONE_TWO, rgc_pkg::REG_RESET);
    rd(rgc_pkg::ADDR_PIN_THREE, rgc_pkg::REG_RESET);
    rd(rgc_pkg::ADDR_PIN_FIVE_SIX, rgc_pkg::REG_RESET);
    cmp("pin_oe", 8'h00, pin_oe);
    wr(8'h11, 8'hFF);
    rd(8'h11, 8'h00);
    wr(rgc_pkg::ADDR_PIN_ONE_TWO, 8'h19);
    rd(rgc_pkg::ADDR_PIN_ONE_TWO, 8'h19);
    cmp("pin_o12", 8'h01, {6'h0, pin_o[1:0] & pin_oe[1:0]});
    cmp("pin_oe12", 8'h03, {6'h0, pin_oe[1:0]});
    for (int m = 0; m < 8; m++) begin
      wr(rgc_pkg::ADDR_PIN_THREE, {5'h01, m[2:0]});
      settle();
      chk_pin(2, exp_pin(m[2:0], 1'b1, 1'b0, 1'b1));
    end
    wr(rgc_pkg::ADDR_PIN_THREE, 8'hFF);
    rd(rgc_pkg::ADDR_PIN_THREE, 8'h0F);
    for (int m = 0; m < 4; m++) begin
      wr(rgc_pkg::ADDR_PIN_FIVE_SIX, {6'h02, m[1:0]});
      settle();
      chk_pin(3, exp_pin({1'b0, m[1:0]}, 1'b1, 1'b0, 1'b1));
    end
    wr(rgc_pkg::ADDR_PIN_FIVE_SIX, 8'hDF);
    rd(rgc_pkg::ADDR_PIN_FIVE_SIX, 8'h9B);
    settle();
    chk_pin(4, 4'hC);
    chk_pin(3, 4'h1);
    val_cmd = 6'h01;
    wr(rgc_pkg::ADDR_PIN_ONE_TWO, 8'hF5);
    settle();
    cmp("pin_o12", 8'h01, {6'h0, pin_o[1:0] & pin_oe[1:0]});
    link_cmd = 2'h2;
    settle();
    cmp("pin_o12", 8'h03, {6'h0, pin_o[1:0] & pin_oe[1:0]});
    cmp("link_status", 8'h00, {7'h0, link_status});
    second_port_select = 1'b1;
    settle();
    cmp("link_status", 8'h01, {7'h0, link_status});
    wr(rgc_pkg::ADDR_PIN_ONE_TWO, 8'h99);
    settle();
    cmp("pin_oe", 8'h77, pin_oe);
    cmp("pin_o67", 8'h03, {6'h0, pin_o[6:5]});
    rd(rgc_pkg::ADDR_PIN_ONE_TWO, 8'h99);
    wr(rgc_pkg::ADDR_PIN_THREE, 8'h0D);
    rd(rgc_pkg::ADDR_PIN_THREE, 8'h0D);
    val_cmd = 6'h21;
    settle();
    cmp("pin_o7", 8'h01, {7'h0, pin_o[7] & pin_oe[7]});
    cmp("pin_o2", 8'h01, {7'h0, pin_o[2] & pin_oe[2]});
    link_cmd = 2'h0;
    settle();
    cmp("pin_o7", 8'h01, {7'h0, pin_o[7] & pin_oe[7]});
    cmp("link_status", 8'h00, {7'h0, link_status});
    rd(rgc_pkg::ADDR_PIN_FIVE_SIX, 8'h9B);
    second_port_select = 1'b0;
    rd(rgc_pkg::ADDR_PIN_ONE_TWO, 8'hF5);
    rd(rgc_pkg::ADDR_PIN_THREE, 8'h0F);
    // Second reset with a loaded configuration
    @(posedge mclk) #1 rst_b = 1'b0;
    repeat (3) @(posedge mclk);
    #1 rst_b = 1'b1;
    cmp("pin_oe", 8'h00, pin_oe);
    rd(rgc_pkg::ADDR_PIN_ONE_TWO, rgc_pkg::REG_RESET);
    rd(rgc_pkg::ADDR_PIN_FIVE_SIX, rgc_pkg::REG_RESET);
    second_port_select = 1'b1;
    rd(rgc_pkg::ADDR_PIN_THREE, rgc_pkg::REG_RESET);
    results();
  end
endmodule
